// File: design/spc_regs.sv
// SRAM parity status and SRAM power mode control register bank.
// Assumes a single-clock AHB-Lite master and an external write lock.
//
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/1ps

module spc_regs (
   // Clock and reset
   input  wire logic        mclk_i,
   input  wire logic        srst_i,
   // AHB-Lite slave
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output logic      [31:0] hrdata_o,
   output logic             hreadyout_o,
   output logic             hresp_o,
   // SRAM parity checker
   input  wire logic        parity_err_i,
   input  wire logic [31:0] parity_addr_i,
   // Power control
   input  wire logic        register_write_lock_i,
   input  wire logic        standby_power_down_i,
   input  wire logic        deepest_power_down_i,
   // Results
   output logic             parity_irq_o,
   output logic      [1:0]  bank0_power_mode_o [4],
   output logic      [1:0]  bank1_power_mode_o [4],
   output logic      [1:0]  retention_period_count_o,
   output logic      [3:0]  stack_macro_o
);

   // ----------------------------------------
   // Bus capture
   // ----------------------------------------
   logic        wr_pend_r;
   logic [7:0]  wr_ofs_r;
   logic        parity_irq_enable_r;
   logic        parity_error_flag_r;
   logic [31:0] parity_fault_byte_address_r;
   logic [31:0] pwr_ctl_r;
   logic [31:0] pwr_ctl_nxt;
   logic [31:0] rd_nxt;
   logic        take;

   assign take = hsel_i && hready_i && htrans_i[1];
   assign hreadyout_o = 1'b1;
   assign hresp_o = 1'b0;

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         wr_pend_r <= 1'b0;
         wr_ofs_r  <= 8'h00;
      end else begin
         wr_pend_r <= take && hwrite_i;
         wr_ofs_r  <= {haddr_i[7:2], 2'h0};
      end
   end

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   always_comb begin
      rd_nxt = 32'h0000_0000;
      unique case ({haddr_i[7:2], 2'h0})
         spc_pkg::OFS_IRQ_EN:   rd_nxt[0] = parity_irq_enable_r;
         spc_pkg::OFS_STATUS:   rd_nxt[0] = parity_error_flag_r;
         spc_pkg::OFS_ERR_ADDR: rd_nxt = parity_fault_byte_address_r;
         spc_pkg::OFS_PWR_CTL:  rd_nxt = pwr_ctl_r;
         default:               rd_nxt = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         hrdata_o <= 32'h0000_0000;
      end else if (take && !hwrite_i) begin
         hrdata_o <= rd_nxt;
      end
   end

   // ----------------------------------------
   // Interrupt enable
   // ----------------------------------------
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         parity_irq_enable_r <= 1'b0;
      end else if (wr_pend_r && wr_ofs_r == spc_pkg::OFS_IRQ_EN) begin
         parity_irq_enable_r <= hwdata_i[0];
      end
   end

   // ----------------------------------------
   // Parity flag and address
   // ----------------------------------------
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         parity_error_flag_r <= 1'b0;
      end else if (parity_err_i) begin
         parity_error_flag_r <= 1'b1;
      end else if (wr_pend_r && wr_ofs_r == spc_pkg::OFS_STATUS
                   && hwdata_i[0]) begin
         parity_error_flag_r <= 1'b0;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         parity_fault_byte_address_r <= 32'h0000_0000;
      end else if (parity_err_i) begin
         parity_fault_byte_address_r <= parity_addr_i;
      end
   end

   assign parity_irq_o = parity_error_flag_r
                         && parity_irq_enable_r;

   // ----------------------------------------
   // Power mode control
   // ----------------------------------------
   always_comb begin
      pwr_ctl_nxt = pwr_ctl_r;
      pwr_ctl_nxt[5:0] = hwdata_i[5:0];
      for (int i = 0; i < 8; i++) begin
         if (hwdata_i[spc_pkg::BANK0_LSB + 2*i +: 2] != spc_pkg::PM_RSVD) begin
            pwr_ctl_nxt[spc_pkg::BANK0_LSB + 2*i +: 2] =
               hwdata_i[spc_pkg::BANK0_LSB + 2*i +: 2];
         end
      end
      pwr_ctl_nxt = pwr_ctl_nxt & spc_pkg::PWR_CTL_MASK;
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         pwr_ctl_r <= spc_pkg::PWR_CTL_RST;
      end else if (wr_pend_r && wr_ofs_r == spc_pkg::OFS_PWR_CTL
                   && !register_write_lock_i) begin
         pwr_ctl_r <= pwr_ctl_nxt;
      end
   end

   assign retention_period_count_o = pwr_ctl_r[spc_pkg::RET_LSB +: 2];
   assign stack_macro_o = pwr_ctl_r[3:0];

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_region
         // Bank 1 regions [17:16] to [23:22]
         assign bank1_power_mode_o[g] =
            (standby_power_down_i || deepest_power_down_i)
            ? spc_pkg::PM_OFF
            : pwr_ctl_r[spc_pkg::BANK1_LSB + 2*g +: 2];
         assign bank0_power_mode_o[g] =
            deepest_power_down_i ? spc_pkg::PM_OFF
            : pwr_ctl_r[spc_pkg::BANK0_LSB + 2*g +: 2];
      end
   endgenerate

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   property p_irq_gate;
      @(posedge mclk_i) disable iff (srst_i)
      parity_irq_o == (parity_error_flag_r && parity_irq_enable_r);
   endproperty
   a_irq_gate: assert property (p_irq_gate)
      else $error("irq gate wrong");

   property p_irq_fire;
      @(posedge mclk_i) disable iff (srst_i)
      (parity_err_i && parity_irq_enable_r
       && !(wr_pend_r && wr_ofs_r == spc_pkg::OFS_IRQ_EN)) |=> parity_irq_o;
   endproperty
   a_irq_fire: assert property (p_irq_fire)
      else $error("irq not raised");

   property p_flag_set;
      @(posedge mclk_i) disable iff (srst_i)
      parity_err_i |=> parity_error_flag_r;
   endproperty
   a_flag_set: assert property (p_flag_set)
      else $error("flag not set");

   property p_flag_clr;
      @(posedge mclk_i) disable iff (srst_i)
      (wr_pend_r && wr_ofs_r == spc_pkg::OFS_STATUS && hwdata_i[0]
       && !parity_err_i) |=> !parity_error_flag_r;
   endproperty
   a_flag_clr: assert property (p_flag_clr)
      else $error("flag not cleared");

   property p_flag_hold;
      @(posedge mclk_i) disable iff (srst_i)
      (!parity_err_i && !(wr_pend_r && wr_ofs_r == spc_pkg::OFS_STATUS
                          && hwdata_i[0])) |=> $stable(parity_error_flag_r);
   endproperty
   a_flag_hold: assert property (p_flag_hold)
      else $error("flag changed without cause");

   property p_addr_cap;
      @(posedge mclk_i) disable iff (srst_i)
      parity_err_i |=> parity_fault_byte_address_r == $past(parity_addr_i);
   endproperty
   a_addr_cap: assert property (p_addr_cap)
      else $error("address not captured");

   property p_addr_hold;
      @(posedge mclk_i) disable iff (srst_i)
      !parity_err_i |=> $stable(parity_fault_byte_address_r);
   endproperty
   a_addr_hold: assert property (p_addr_hold)
      else $error("address changed without error");

   property p_en_hold;
      @(posedge mclk_i) disable iff (srst_i)
      !(wr_pend_r && wr_ofs_r == spc_pkg::OFS_IRQ_EN)
      |=> $stable(parity_irq_enable_r);
   endproperty
   a_en_hold: assert property (p_en_hold)
      else $error("enable changed without write");

   property p_en_write;
      @(posedge mclk_i) disable iff (srst_i)
      (wr_pend_r && wr_ofs_r == spc_pkg::OFS_IRQ_EN)
      |=> parity_irq_enable_r == $past(hwdata_i[0]);
   endproperty
   a_en_write: assert property (p_en_write)
      else $error("enable write lost");

   property p_no_rsvd;
      @(posedge mclk_i) disable iff (srst_i)
      pwr_ctl_r[9:8] != spc_pkg::PM_RSVD
      && pwr_ctl_r[23:22] != spc_pkg::PM_RSVD;
   endproperty
   a_no_rsvd: assert property (p_no_rsvd)
      else $error("reserved mode stored");

   property p_rsvd_keep;
      @(posedge mclk_i) disable iff (srst_i)
      (wr_pend_r && wr_ofs_r == spc_pkg::OFS_PWR_CTL
       && !register_write_lock_i && hwdata_i[23:22] == spc_pkg::PM_RSVD)
      |=> $stable(pwr_ctl_r[23:22]);
   endproperty
   a_rsvd_keep: assert property (p_rsvd_keep)
      else $error("reserved code changed field");

   property p_locked;
      @(posedge mclk_i) disable iff (srst_i)
      register_write_lock_i |=> $stable(pwr_ctl_r);
   endproperty
   a_locked: assert property (p_locked)
      else $error("locked write taken");

   property p_ctl_low;
      @(posedge mclk_i) disable iff (srst_i)
      (wr_pend_r && wr_ofs_r == spc_pkg::OFS_PWR_CTL
       && !register_write_lock_i)
      |=> pwr_ctl_r[5:0] == $past(hwdata_i[5:0]);
   endproperty
   a_ctl_low: assert property (p_ctl_low)
      else $error("count or stack write lost");

   property p_spd_off;
      @(posedge mclk_i) disable iff (srst_i)
      standby_power_down_i |-> bank1_power_mode_o[3] == spc_pkg::PM_OFF;
   endproperty
   a_spd_off: assert property (p_spd_off)
      else $error("bank 1 not off");

   property p_dpd_off;
      @(posedge mclk_i) disable iff (srst_i)
      deepest_power_down_i |-> bank0_power_mode_o[0] == spc_pkg::PM_OFF;
   endproperty
   a_dpd_off: assert property (p_dpd_off)
      else $error("bank 0 not off");

   property p_b1_dpd;
      @(posedge mclk_i) disable iff (srst_i)
      deepest_power_down_i |-> bank1_power_mode_o[0] == spc_pkg::PM_OFF;
   endproperty
   a_b1_dpd: assert property (p_b1_dpd)
      else $error("bank 1 not off in deep mode");

   property p_b0_spd;
      @(posedge mclk_i) disable iff (srst_i)
      (standby_power_down_i && !deepest_power_down_i)
      |-> bank0_power_mode_o[1] == pwr_ctl_r[11:10];
   endproperty
   a_b0_spd: assert property (p_b0_spd)
      else $error("bank 0 forced in standby");

   property p_b1_map;
      @(posedge mclk_i) disable iff (srst_i)
      !(standby_power_down_i || deepest_power_down_i)
      |-> bank1_power_mode_o[3] == pwr_ctl_r[23:22]
          && bank1_power_mode_o[2] == pwr_ctl_r[21:20]
          && bank1_power_mode_o[1] == pwr_ctl_r[19:18];
   endproperty
   a_b1_map: assert property (p_b1_map)
      else $error("bank 1 field mapping wrong");

   property p_rd_rsvd;
      @(posedge mclk_i) disable iff (srst_i)
      (take && !hwrite_i && {haddr_i[7:2], 2'h0} == spc_pkg::OFS_STATUS)
      |=> hrdata_o[31:1] == 31'h0000_0000;
   endproperty
   a_rd_rsvd: assert property (p_rd_rsvd)
      else $error("status reserved bits not zero");

   property p_rsvd_zero;
      @(posedge mclk_i) disable iff (srst_i)
      (pwr_ctl_r & ~spc_pkg::PWR_CTL_MASK) == 32'h0000_0000;
   endproperty
   a_rsvd_zero: assert property (p_rsvd_zero)
      else $error("reserved bit set");

   c_irq: cover property (@(posedge mclk_i) parity_irq_o);
   c_clr: cover property (@(posedge mclk_i)
      parity_error_flag_r ##1 !parity_error_flag_r);
   c_pwr: cover property (@(posedge mclk_i) $changed(pwr_ctl_r));
   c_race: cover property (@(posedge mclk_i)
      parity_err_i && wr_pend_r && wr_ofs_r == spc_pkg::OFS_STATUS);
   c_deep: cover property (@(posedge mclk_i) deepest_power_down_i);

endmodule

// File: design/spc_pkg.sv
// Constants for the SRAM parity and power control register bank.
// Assumes an AHB-Lite slave on a 32-bit system register space.
//
// Notes on behaviour
// - Enable bit 0 gates the parity error interrupt; 1 allows it.
// - Parity error flag sets on any SRAM parity error; reads 0 otherwise.
// - Writing 1 clears the flag; writing 0 leaves it unchanged.
// - Read-only 32-bit register reports the failing byte address.
// - Each 2-bit power mode: 00 normal, 01 retention, 10 shut off.
// - Writing code 11 to a power mode field is ignored.
// - Bank 1 field [23:22] controls 0x2001_4000 to 0x2001_7FFF.
// - Bank 1 field [21:20] controls 0x2001_0000 to 0x2001_3FFF.
// - Bank 1 field [19:18] controls 0x2000_C000 to 0x2000_FFFF.
// - Standby or deepest power-down forces every bank 1 region off.
// - Power mode fields are writable only while the write lock is open.
// - Bank 0 fields at [15:8] use the same encoding; [9:8] is lowest.
// - Deepest power-down forces bank 0 off regardless of its fields.
// - Retention count sets time in oscillator periods: 00 one, 11 four.
// - Write-protected field [3:0] names the first-access SRAM macro.

package spc_pkg;

   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [7:0]  OFS_IRQ_EN   = 8'hc0;
   localparam logic [7:0]  OFS_STATUS   = 8'hc4;
   localparam logic [7:0]  OFS_ERR_ADDR = 8'hc8;
   localparam logic [7:0]  OFS_PWR_CTL  = 8'hdc;

   // ----------------------------------------
   // Fields and reset values
   // ----------------------------------------
   localparam int          BANK0_LSB    = 8;
   localparam int          BANK1_LSB    = 16;
   localparam int          RET_LSB      = 4;
   localparam logic [31:0] PWR_CTL_RST  = 32'h0000_0020;
   localparam logic [31:0] PWR_CTL_MASK = 32'h00ff_ff3f;
   localparam logic [1:0]  PM_NORMAL    = 2'h0;
   localparam logic [1:0]  PM_RETAIN    = 2'h1;
   localparam logic [1:0]  PM_OFF       = 2'h2;
   localparam logic [1:0]  PM_RSVD      = 2'h3;

   // ----------------------------------------
   // Bus codes
   // ----------------------------------------
   localparam logic [1:0]  HTRANS_NSEQ  = 2'h2;

endpackage

// File: dv/spc_regs_tb.sv
// Self-checking bench for the SRAM parity and power control bank.
// Assumes spc_pkg and spc_regs compiled first; bench is bus master.
`timescale 1ns/1ps

module spc_regs_tb;
   logic        mclk_i   = 1'b0;
   logic        srst_i   = 1'b1;
   logic        hsel_i   = 1'b0;
   logic [31:0] haddr_i  = 32'h0;
   logic [1:0]  htrans_i = 2'h0;
   logic        hwrite_i = 1'b0;
   logic [31:0] hwdata_i = 32'h0;
   logic        perr     = 1'b0;
   logic [31:0] paddr    = 32'h0;
   logic        lock     = 1'b1;
   logic        sb       = 1'b0;
   logic        dp       = 1'b0;
   logic [31:0] hrdata_o;
   logic        hreadyout_o;
   logic        hresp_o;
   logic        irq;
   logic [1:0]  b0 [4];
   logic [1:0]  b1 [4];
   logic [1:0]  ret;
   logic [3:0]  stk;
   int          n_mismatch  = 0;
   int          check_count = 0;

   always #12.5 mclk_i = ~mclk_i;

   spc_regs dut (.mclk_i(mclk_i), .srst_i(srst_i), .hsel_i(hsel_i),
      .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
      .hsize_i(3'h2), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
      .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
      .parity_err_i(perr), .parity_addr_i(paddr),
      .register_write_lock_i(lock), .standby_power_down_i(sb),
      .deepest_power_down_i(dp), .parity_irq_o(irq),
      .bank0_power_mode_o(b0), .bank1_power_mode_o(b1),
      .retention_period_count_o(ret), .stack_macro_o(stk));

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [31:0] e, g);
      check_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
      hsel_i   <= 1'b1;
      haddr_i  <= {24'h0, a};
      htrans_i <= spc_pkg::HTRANS_NSEQ;
      hwrite_i <= w;
      @(posedge mclk_i);
      while (hreadyout_o !== 1'b1) @(posedge mclk_i);
      hsel_i   <= 1'b0;
      htrans_i <= 2'h0;
      hwdata_i <= wd;
      @(posedge mclk_i);
      while (hreadyout_o !== 1'b1) @(posedge mclk_i);
      rd = hrdata_o;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask

   task automatic rdc(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
      logic [31:0] x;
      bus(1'b0, a, 32'h0, x);
      chk(nm, e, x);
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset();
      rdc("irq_en", spc_pkg::OFS_IRQ_EN, 32'h0);
      rdc("status", spc_pkg::OFS_STATUS, 32'h0);
      rdc("err_addr", spc_pkg::OFS_ERR_ADDR, 32'h0);
      rdc("pwr_ctl", spc_pkg::OFS_PWR_CTL, 32'h20);
      wr(8'hd0, 32'hffff_ffff);
      rdc("unmapped", 8'hd0, 32'h0);
      chk("hresp", 32'(hresp_o), 32'h0);
      chk("irq", 32'(irq), 32'h0);
      $display("reset test done");
   endtask

   task automatic t_parity();
      wr(spc_pkg::OFS_IRQ_EN, 32'hffff_ffff);
      rdc("irq_en", spc_pkg::OFS_IRQ_EN, 32'h1);
      perr  <= 1'b1;
      paddr <= 32'h2000_1235;
      @(posedge mclk_i);
      perr  <= 1'b0;
      paddr <= 32'h2000_0abc;
      @(posedge mclk_i);
      chk("irq set", 32'(irq), 32'h1);
      rdc("status", spc_pkg::OFS_STATUS, 32'h1);
      rdc("err_addr", spc_pkg::OFS_ERR_ADDR, 32'h2000_1235);
      wr(spc_pkg::OFS_STATUS, 32'hffff_fffe);
      rdc("status w0", spc_pkg::OFS_STATUS, 32'h1);
      wr(spc_pkg::OFS_IRQ_EN, 32'h0);
      @(posedge mclk_i);
      chk("irq masked", 32'(irq), 32'h0);
      wr(spc_pkg::OFS_IRQ_EN, 32'h1);
      wr(spc_pkg::OFS_STATUS, 32'h1);
      @(posedge mclk_i);
      chk("irq clr", 32'(irq), 32'h0);
      rdc("status w1", spc_pkg::OFS_STATUS, 32'h0);
      $display("parity test done");
   endtask

   task automatic t_power();
      wr(spc_pkg::OFS_PWR_CTL, 32'h00aa_aa15);
      rdc("locked", spc_pkg::OFS_PWR_CTL, 32'h20);
      lock <= 1'b0;
      wr(spc_pkg::OFS_PWR_CTL, 32'hff92_92d5);
      rdc("pwr_ctl", spc_pkg::OFS_PWR_CTL, 32'h0092_9215);
      chk("b1 r3", 32'(b1[3]), 32'(spc_pkg::PM_OFF));
      chk("b1 r2", 32'(b1[2]), 32'(spc_pkg::PM_RETAIN));
      chk("b1 r1", 32'(b1[1]), 32'(spc_pkg::PM_NORMAL));
      chk("b0 r0", 32'(b0[0]), 32'(spc_pkg::PM_OFF));
      chk("ret", 32'(ret), 32'h1);
      chk("stack", 32'(stk), 32'h5);
      wr(spc_pkg::OFS_PWR_CTL, 32'h00ed_0036);
      rdc("code 11", spc_pkg::OFS_PWR_CTL, 32'h00a1_0036);
      chk("ret max", 32'(ret), 32'h3);
      $display("power test done");
   endtask

   task automatic t_pd();
      sb <= 1'b1;
      @(posedge mclk_i);
      @(posedge mclk_i);
      for (int i = 0; i < 4; i++) begin
         chk("b1 standby", 32'(b1[i]), 32'(spc_pkg::PM_OFF));
         chk("b0 standby", 32'(b0[i]), 32'h0);
      end
      sb <= 1'b0;
      dp <= 1'b1;
      @(posedge mclk_i);
      @(posedge mclk_i);
      for (int i = 0; i < 4; i++) begin
         chk("b1 deep", 32'(b1[i]), 32'(spc_pkg::PM_OFF));
         chk("b0 deep", 32'(b0[i]), 32'(spc_pkg::PM_OFF));
      end
      $display("power-down test done");
   endtask

   task automatic t_race();
      logic [31:0] x;
      fork
         bus(1'b1, spc_pkg::OFS_STATUS, 32'h1, x);
         begin
            @(posedge mclk_i);
            perr  <= 1'b1;
            paddr <= 32'h2001_4008;
            @(posedge mclk_i);
            perr  <= 1'b0;
         end
      join
      rdc("set wins", spc_pkg::OFS_STATUS, 32'h1);
      rdc("latest addr", spc_pkg::OFS_ERR_ADDR, 32'h2001_4008);
      $display("race test done");
   endtask

   task automatic t_rst_mid();
      dp     <= 1'b0;
      srst_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      srst_i <= 1'b0;
      @(posedge mclk_i);
      chk("irq rst", 32'(irq), 32'h0);
      chk("b0 rst", 32'(b0[0]), 32'(spc_pkg::PM_NORMAL));
      rdc("irq_en rst", spc_pkg::OFS_IRQ_EN, 32'h0);
      rdc("status rst", spc_pkg::OFS_STATUS, 32'h0);
      rdc("addr rst", spc_pkg::OFS_ERR_ADDR, 32'h0);
      rdc("pwr rst", spc_pkg::OFS_PWR_CTL, 32'h20);
      $display("mid-run reset test done");
   endtask

   initial begin
      repeat (4) @(posedge mclk_i);
      srst_i <= 1'b0;
      @(posedge mclk_i);
      t_reset();
      t_parity();
      t_race();
      t_power();
      t_pd();
      t_rst_mid();
      results();
   end

   initial begin
      repeat (3000) @(posedge mclk_i);
      n_mismatch++;
      results();
   end
endmodule
